// [hw/cgm_fifo.sv]
`timescale 1ns/1ps
`include "cgm_map.svh"

module cgm_fifo
   import cgm_pkg::*;
#(
   parameter int W     = $bits(cgm_pair_t),
   parameter int DEPTH = `CGM_FIFO_DEPTH
)
(
   input  wire logic   i_ref_clk,
   input  wire logic   i_reset,
   cgm_stream_if.snk   s_push,
   cgm_stream_if.src   s_pop
);

   localparam int AW = $clog2(DEPTH);

   logic [W-1:0]  mem_reg [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0]   fill_reg;
   logic          do_push;
   logic          do_pop;

   // honest flags from the fill count
   assign s_push.ready = (fill_reg != (AW+1)'(DEPTH));
   assign s_pop.valid  = (fill_reg != '0);
   assign s_pop.data   = cgm_pair_t'(mem_reg[rd_ptr_reg]);
   assign do_push      = s_push.valid & s_push.ready;
   assign do_pop       = s_pop.valid & s_pop.ready;

   // storage has no reset, only the pointers matter
   always_ff @(posedge i_ref_clk)
   begin
      if (do_push)
         mem_reg[wr_ptr_reg] <= W'(s_push.data);
   end

   // pointers wrap since depth is a power of two
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         fill_reg   <= '0;
      end
      else
      begin
         if (do_push)
            wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (do_pop)
            rd_ptr_reg <= rd_ptr_reg + 1'b1;
         if (do_push & ~do_pop)
            fill_reg <= fill_reg + 1'b1;
         else if (do_pop & ~do_push)
            fill_reg <= fill_reg - 1'b1;
      end
   end

endmodule : cgm_fifo

// [hw/cgm_gain_mute.sv]
`timescale 1ns/1ps
`include "cgm_map.svh"

module cgm_gain_mute
   import cgm_pkg::*;
#(
   parameter int unsigned MS_CYCLES = (`CGM_MS_NS + `CGM_CLK_NS - 1) / `CGM_CLK_NS
)
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic [7:0]  i_reg_addr,
   input  wire logic        i_reg_wr,
   input  wire logic        i_reg_rd,
   input  wire logic [7:0]  i_reg_wdata,
   output logic      [7:0]  o_reg_rdata,
   input  wire logic        i_global_mute,
   input  wire logic [1:0]  i_limit_hit,
   output logic      [1:0]  o_limit_status,
   input  wire logic        i_hold_start,
   input  wire logic        i_release_start,
   output logic             o_hold_active,
   output logic             o_release_active,
   input  wire logic        i_in_valid,
   output logic             o_in_ready,
   input  wire logic [23:0] i_in_left,
   input  wire logic [23:0] i_in_right,
   output logic             o_out_valid,
   input  wire logic        i_out_ready,
   output logic      [23:0] o_out_left,
   output logic      [23:0] o_out_right
);

   ////////////////////////////////////////////////////////////////////////////////
   // register file

   logic [15:0] gain_ctrl_reg;
   logic [7:0]  silence_reg;
   logic [7:0]  master_reg;
   logic [7:0]  level_reg [2];
   logic [7:0]  hold_reg;
   logic [7:0]  release_reg;
   logic        limit_clear;

   // byte writes at the page-2 offsets, reserved bits stored as written
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         gain_ctrl_reg <= `CGM_RST_GAIN_CTRL;
         silence_reg   <= `CGM_RST_SILENCE;
         master_reg    <= `CGM_RST_MASTER;
         level_reg[0]  <= `CGM_RST_LEVEL;
         level_reg[1]  <= `CGM_RST_LEVEL;
         hold_reg      <= `CGM_RST_TIMER;
         release_reg   <= `CGM_RST_TIMER;
      end
      else if (i_reg_wr)
      begin
         unique case (i_reg_addr)
            `CGM_OFS_GAIN_UPPER : gain_ctrl_reg[15:8] <= i_reg_wdata;
            `CGM_OFS_GAIN_LOWER : gain_ctrl_reg[7:0]  <= i_reg_wdata;
            `CGM_OFS_SILENCE    : silence_reg         <= i_reg_wdata;
            `CGM_OFS_MASTER     : master_reg          <= i_reg_wdata;
            `CGM_OFS_LEFT_LVL   : level_reg[0]        <= i_reg_wdata;
            `CGM_OFS_RIGHT_LVL  : level_reg[1]        <= i_reg_wdata;
            `CGM_OFS_HOLD_TIMER : hold_reg            <= i_reg_wdata;
            `CGM_OFS_REL_TIMER  : release_reg         <= i_reg_wdata;
            default             : ;
         endcase
      end
   end

   // read data held in a flop, unmapped offsets answer zero
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         o_reg_rdata <= 8'h00;
      else if (i_reg_rd)
      begin
         unique case (i_reg_addr)
            `CGM_OFS_GAIN_UPPER : o_reg_rdata <= gain_ctrl_reg[15:8];
            `CGM_OFS_GAIN_LOWER : o_reg_rdata <= gain_ctrl_reg[7:0];
            `CGM_OFS_SILENCE    : o_reg_rdata <= silence_reg;
            `CGM_OFS_MASTER     : o_reg_rdata <= master_reg;
            `CGM_OFS_LEFT_LVL   : o_reg_rdata <= level_reg[0];
            `CGM_OFS_RIGHT_LVL  : o_reg_rdata <= level_reg[1];
            `CGM_OFS_HOLD_TIMER : o_reg_rdata <= hold_reg;
            `CGM_OFS_REL_TIMER  : o_reg_rdata <= release_reg;
            default             : o_reg_rdata <= 8'h00;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // limit latches

   // a write of the lower gain byte with the clear bit set
   assign limit_clear = i_reg_wr & (i_reg_addr == `CGM_OFS_GAIN_LOWER)
                        & i_reg_wdata[`CGM_GC_CLR_LIMIT];

   // a new hit in the clearing cycle survives
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         o_limit_status <= 2'b00;
      else
         o_limit_status <= (limit_clear ? 2'b00 : o_limit_status) | i_limit_hit;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // time base

   logic [31:0] ms_cnt_reg;
   logic [3:0]  decade_reg;
   logic        tick_1ms;
   logic        tick_10ms;
   logic        unit_tick;
   logic [7:0]  step_cnt_reg;
   logic [7:0]  step_interval;
   logic        step_pulse_reg;

   assign tick_1ms  = (ms_cnt_reg == 32'(MS_CYCLES - 1));
   assign tick_10ms = tick_1ms & (decade_reg == `CGM_COARSE_LAST);

   // free-running millisecond and ten-millisecond dividers
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         ms_cnt_reg <= '0;
         decade_reg <= '0;
      end
      else
      begin
         ms_cnt_reg <= tick_1ms ? '0 : ms_cnt_reg + 32'h0000_0001;
         if (tick_10ms)
            decade_reg <= '0;
         else if (tick_1ms)
            decade_reg <= decade_reg + 4'h1;
      end
   end

   // ramp interval counted in whichever unit is picked
   assign unit_tick     = gain_ctrl_reg[`CGM_GC_COARSE] ? tick_10ms : tick_1ms;
   assign step_interval = `CGM_STEP_ONE
                          << gain_ctrl_reg[`CGM_GC_STEP_EXP_LO +: 3];

   // phase of the first step is not aligned to the register write
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         step_cnt_reg   <= '0;
         step_pulse_reg <= 1'b0;
      end
      else
      begin
         step_pulse_reg <= 1'b0;
         if (unit_tick)
         begin
            if (step_cnt_reg >= step_interval - `CGM_STEP_ONE)
            begin
               step_cnt_reg   <= '0;
               step_pulse_reg <= 1'b1;
            end
            else
               step_cnt_reg <= step_cnt_reg + 8'h01;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // limiter hold and release timers

   logic [7:0] tm_cfg   [2];
   logic       tm_start [2];
   logic       tm_busy  [2];

   assign tm_cfg[0]        = hold_reg;
   assign tm_cfg[1]        = release_reg;
   assign tm_start[0]      = i_hold_start;
   assign tm_start[1]      = i_release_start;
   assign o_hold_active    = tm_busy[0];
   assign o_release_active = tm_busy[1];

   for (genvar t = 0; t < 2; t++)
   begin : g_timer
      logic [6:0] left_reg;
      logic       tick_sel;

      // count unit chosen by the top bit of the timer byte
      assign tick_sel   = tm_cfg[t][`CGM_TM_COARSE] ? tick_10ms : tick_1ms;
      assign tm_busy[t] = (left_reg != 7'h00);

      // first unit may run short by up to one tick period
      always_ff @(posedge i_ref_clk or posedge i_reset)
      begin
         if (i_reset)
            left_reg <= 7'h00;
         else if (tm_start[t])
            left_reg <= tm_cfg[t][6:0];
         else if (tick_sel & tm_busy[t])
            left_reg <= left_reg - 7'h01;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // zero-run detector

   logic [12:0]    zrun_reg;
   logic [12:0]    zrun_len;
   logic           auto_silent;
   logic           accept;
   cgm_mute_kind_t mute_kind;
   logic           bypass;

   assign accept    = i_in_valid & o_in_ready;
   assign mute_kind = cgm_mute_kind_t'(gain_ctrl_reg[`CGM_GC_MUTE_HARD]);
   assign bypass    = gain_ctrl_reg[`CGM_GC_BYPASS];
   assign zrun_len  = `CGM_ZRUN_BASE << gain_ctrl_reg[`CGM_GC_ZLEN_LO +: 2];

   // counts sample pairs with both channels zero, saturating
   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
         zrun_reg <= '0;
      else if (accept)
      begin
         if ((i_in_left != 24'h000000) || (i_in_right != 24'h000000))
            zrun_reg <= '0;
         else if (zrun_reg != `CGM_ZRUN_MAX)
            zrun_reg <= zrun_reg + 13'h0001;
      end
   end

   assign auto_silent = gain_ctrl_reg[`CGM_GC_AUTO_SILENCE]
                        & (zrun_reg > zrun_len);

   ////////////////////////////////////////////////////////////////////////////////
   // per-channel gain

   // two to the power of minus k over twelve, unsigned with 15 fraction bits
   function automatic logic [15:0] cgm_mantissa(input logic [3:0] k);
      logic [15:0] m;
      m = 16'h8000;
      unique case (k)
         4'h0    : m = 16'h8000;
         4'h1    : m = 16'h78d1;
         4'h2    : m = 16'h7209;
         4'h3    : m = 16'h6ba2;
         4'h4    : m = 16'h6598;
         4'h5    : m = 16'h5fe4;
         4'h6    : m = 16'h5a82;
         4'h7    : m = 16'h556e;
         4'h8    : m = 16'h50a3;
         4'h9    : m = 16'h4c1c;
         4'ha    : m = 16'h47d6;
         4'hb    : m = 16'h43ce;
         default : m = 16'h0000;
      endcase
      return m;
   endfunction : cgm_mantissa

   cgm_sample_t ch_in  [2];
   cgm_sample_t ch_out [2];

   assign ch_in[0] = cgm_sample_t'(i_in_left);
   assign ch_in[1] = cgm_sample_t'(i_in_right);

   for (genvar c = 0; c < 2; c++)
   begin : g_chan
      logic [7:0]          cur_reg;
      logic [7:0]          cur_next;
      logic                sign_reg;
      logic                step_due_reg;
      logic                want_mute;
      logic [7:0]          target;
      logic                crossing;
      logic                may_change;
      logic                ramping;
      logic [8:0]          master_cut_level_sum;
      logic [8:0]          octave;
      logic [8:0]          fraction;
      logic [6:0]          shift;
      logic signed [40:0]  product;
      logic signed [40:0]  scaled;
      logic                silent;

      // any mute source drives the target to the mute code
      assign want_mute = silence_reg[c] | i_global_mute | auto_silent;
      assign target    = want_mute ? `CGM_CODE_MUTE : level_reg[c];
      assign crossing  = (ch_in[c] == 24'sh000000)
                         | (ch_in[c][23] != sign_reg);
      assign may_change = gain_ctrl_reg[`CGM_GC_CHANGE_NOW] | crossing;
      // soft mute reuses the ramp so silence fades in
      assign ramping   = gain_ctrl_reg[`CGM_GC_STEPPED]
                         | (want_mute & (mute_kind == CGM_SOFT_MUTE));

      // a step tick is remembered until a sample can spend it
      always_ff @(posedge i_ref_clk or posedge i_reset)
      begin
         if (i_reset)
            step_due_reg <= 1'b0;
         else if (step_pulse_reg)
            step_due_reg <= 1'b1;
         else if (accept & may_change)
            step_due_reg <= 1'b0;
      end

      // the sample being taken already uses the new level, so no sample of lag
      always_comb
      begin
         cur_next = cur_reg;
         if (may_change & (cur_reg != target) & !ramping)
            cur_next = target;
         else if (may_change & (cur_reg != target) & step_due_reg)
            cur_next = (cur_reg < target) ? cur_reg + 8'h01 : cur_reg - 8'h01;
      end

      // level in use moves at sample boundaries only
      always_ff @(posedge i_ref_clk or posedge i_reset)
      begin
         if (i_reset)
         begin
            cur_reg  <= `CGM_RST_LEVEL;
            sign_reg <= 1'b0;
         end
         else if (accept)
         begin
            sign_reg <= ch_in[c][23];
            cur_reg  <= cur_next;
         end
      end

      // sum of 0x48 is unity gain, smaller sums give up to +36 dB of gain
      assign master_cut_level_sum = {1'b0, cur_next} + {1'b0, master_reg};
      assign octave    = master_cut_level_sum / `CGM_CODE_STEPS;
      assign fraction  = master_cut_level_sum % `CGM_CODE_STEPS;
      assign shift     = `CGM_SHIFT_BASE + octave[6:0];
      assign product   = ch_in[c] * $signed({1'b0, cgm_mantissa(fraction[3:0])});
      assign scaled    = product >>> shift;
      // hard mute bypasses the ramp, FFh codes silence unless bypass is set
      assign silent    = (cur_next == `CGM_CODE_MUTE)
                         | (master_reg == `CGM_CODE_MUTE)
                         | (want_mute & (mute_kind == CGM_HARD_MUTE));

      // saturate back into 24 bits after the +36 dB headroom
      always_comb
      begin
         if (bypass)
            ch_out[c] = ch_in[c];
         else if (silent)
            ch_out[c] = 24'sh000000;
         else if (scaled > 41'sh00000_7fffff)
            ch_out[c] = 24'sh7fffff;
         else if (scaled < -41'sh00000_800000)
            ch_out[c] = 24'sh800000;
         else
            ch_out[c] = scaled[23:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // output stage and buffer

   cgm_stream_if to_fifo ();
   cgm_stream_if from_fifo ();

   logic      stage_valid_reg;
   cgm_pair_t stage_data_reg;

   // stage refills whenever the buffer takes its word
   assign o_in_ready = ~stage_valid_reg | to_fifo.ready;

   always_ff @(posedge i_ref_clk or posedge i_reset)
   begin
      if (i_reset)
      begin
         stage_valid_reg <= 1'b0;
         stage_data_reg  <= '0;
      end
      else if (o_in_ready)
      begin
         stage_valid_reg <= i_in_valid;
         if (i_in_valid)
            stage_data_reg <= '{left: ch_out[0], right: ch_out[1]};
      end
   end

   assign to_fifo.valid = stage_valid_reg;
   assign to_fifo.data  = stage_data_reg;

   cgm_fifo #(
      .W     ($bits(cgm_pair_t)),
      .DEPTH (`CGM_FIFO_DEPTH)
   ) u_fifo (
      .i_ref_clk (i_ref_clk),
      .i_reset   (i_reset),
      .s_push    (to_fifo),
      .s_pop     (from_fifo)
   );

   // downstream stall fills the buffer and then blocks input
   assign from_fifo.ready = i_out_ready;
   assign o_out_valid     = from_fifo.valid;
   assign o_out_left      = from_fifo.data.left;
   assign o_out_right     = from_fifo.data.right;

endmodule : cgm_gain_mute

// [hw/cgm_map.svh]
`ifndef CGM_MAP_SVH
`define CGM_MAP_SVH

// page-2 register offsets
`define CGM_OFS_REL_TIMER   8'h22
`define CGM_OFS_GAIN_UPPER  8'h23
`define CGM_OFS_GAIN_LOWER  8'h24
`define CGM_OFS_SILENCE     8'h26
`define CGM_OFS_MASTER      8'h27
`define CGM_OFS_LEFT_LVL    8'h28
`define CGM_OFS_RIGHT_LVL   8'h29
`define CGM_OFS_HOLD_TIMER  8'h2a

// reset values
`define CGM_RST_GAIN_CTRL   16'h1505
`define CGM_RST_SILENCE     8'h00
`define CGM_RST_MASTER      8'h00
`define CGM_RST_LEVEL       8'h48
`define CGM_RST_TIMER       8'h00

// gain control field positions
`define CGM_GC_MUTE_HARD    0
`define CGM_GC_CHANGE_NOW   1
`define CGM_GC_AUTO_SILENCE 2
`define CGM_GC_BYPASS       3
`define CGM_GC_STEPPED      4
`define CGM_GC_COARSE       5
`define CGM_GC_CLR_LIMIT    7
`define CGM_GC_STEP_EXP_LO  8
`define CGM_GC_ZLEN_LO      11

// timer field positions
`define CGM_TM_COARSE       7

// codes and lengths
`define CGM_CODE_MUTE       8'hff
`define CGM_ZRUN_BASE       13'h0200
`define CGM_ZRUN_MAX        13'h1fff
`define CGM_STEP_ONE        8'h01
`define CGM_CODE_STEPS      9'd12
`define CGM_SHIFT_BASE      7'd9

// timing
`define CGM_MS_NS           1000000
`define CGM_CLK_NS          10
`define CGM_COARSE_LAST     4'h9
`define CGM_FIFO_DEPTH      32

`endif

// [hw/cgm_pkg.sv]
package cgm_pkg;

   typedef logic signed [23:0] cgm_sample_t;

   typedef struct packed
   {
      cgm_sample_t left;
      cgm_sample_t right;
   } cgm_pair_t;

   typedef enum logic
   {
      CGM_SOFT_MUTE,
      CGM_HARD_MUTE
   } cgm_mute_kind_t;

endpackage : cgm_pkg

// [hw/cgm_stream_if.sv]
`timescale 1ns/1ps

interface cgm_stream_if;
   import cgm_pkg::*;

   logic      valid;
   logic      ready;
   cgm_pair_t data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface : cgm_stream_if

// [verif/cgm_far_model.sv]
`timescale 1ns/1ps

module cgm_far_model
(
   input  wire logic        i_ref_clk,
   input  wire logic        i_reset,
   input  wire logic        i_stall,
   input  wire logic        i_valid,
   input  wire logic [47:0] i_word,
   output logic             o_ready,
   output logic             o_got,
   output logic [47:0]      o_word
);
   // downstream sink: ready is registered, so a stall shows one edge late
   always_ff @(posedge i_ref_clk or posedge i_reset)
      if (i_reset)
      begin
         o_ready <= 1'b0;
         o_got   <= 1'b0;
      end
      else
      begin
         o_ready <= !i_stall;
         o_got   <= i_valid && o_ready;
         if (i_valid && o_ready) o_word <= i_word;
      end
endmodule : cgm_far_model

// [verif/cgm_gain_mute_checker.sv]
`timescale 1ns/1ps

module cgm_gain_mute_checker
#(
   parameter int unsigned MS_CYCLES = 10
)
(
   input wire logic        i_ref_clk,
   input wire logic        i_reset,
   input wire logic [7:0]  i_reg_addr,
   input wire logic        i_reg_wr,
   input wire logic [7:0]  i_reg_wdata,
   input wire logic        i_global_mute,
   input wire logic [1:0]  i_limit_hit,
   input wire logic [1:0]  o_limit_status,
   input wire logic        i_hold_start,
   input wire logic        o_hold_active,
   input wire logic        i_in_valid,
   input wire logic        o_in_ready,
   input wire logic [23:0] i_in_left,
   input wire logic        o_out_valid,
   input wire logic        i_out_ready,
   input wire logic [23:0] o_out_left,
   input wire logic [23:0] o_out_right
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);

   logic [7:0] hold_reg;
   logic [7:0] gc_lo_reg;
   int         hold_cnt;
   int         hold_max;
   logic       clr_wr;
   logic       acc;

   // shadows of the fields the properties depend on
   assign clr_wr = i_reg_wr && i_reg_addr == 8'h24 && i_reg_wdata[7];
   assign acc = i_in_valid && o_in_ready;
   assign hold_max = (hold_reg[6:0] + 1) * (hold_reg[7] ? 10 : 1) * MS_CYCLES + 2;

   always_ff @(posedge i_ref_clk or posedge i_reset)
      if (i_reset) hold_reg <= 8'h00;
      else if (i_reg_wr && i_reg_addr == 8'h2a) hold_reg <= i_reg_wdata;

   always_ff @(posedge i_ref_clk or posedge i_reset)
      if (i_reset) gc_lo_reg <= 8'h05;
      else if (i_reg_wr && i_reg_addr == 8'h24) gc_lo_reg <= i_reg_wdata;

   // length of the current active stretch; restart reloads it
   always_ff @(posedge i_ref_clk or posedge i_reset)
      if (i_reset) hold_cnt <= 0;
      else if (!o_hold_active || i_hold_start) hold_cnt <= 0;
      else hold_cnt <= hold_cnt + 1;

   ////////////////////////////////////////////////////////////////////////////
   // a sample taken while nothing else is in flight comes out two edges later
   sequence lone_acc;
      !o_out_valid && !$past(acc) && acc;
   endsequence

   limit_set_a: assert property (i_limit_hit[0] |=> o_limit_status[0])
      else $error("limit flag not latched");
   limit_clr_a: assert property (clr_wr && i_limit_hit == 2'b00 |=> o_limit_status == 2'b00)
      else $error("limit flags not cleared");
   limit_keep_a: assert property (o_limit_status[1] && !clr_wr |=> o_limit_status[1])
      else $error("limit flag lost");
   hold_go_a: assert property (i_hold_start && hold_reg[6:0] != 7'h00 && !i_reg_wr |=> o_hold_active)
      else $error("hold timer did not start");
   hold_idle_a: assert property (i_hold_start && hold_reg[6:0] == 7'h00 && !i_reg_wr |=> !o_hold_active)
      else $error("hold timer active on zero load");
   hold_len_a: assert property (hold_cnt <= hold_max)
      else $error("hold timer ran too long");
   all_mute_a: assert property (lone_acc ##0 (i_global_mute && gc_lo_reg[0] && !gc_lo_reg[3])
      |-> ##2 o_out_valid && o_out_left == 24'h000000 && o_out_right == 24'h000000)
      else $error("global mute let a sample through");
   bypass_pass_a: assert property (lone_acc ##0 gc_lo_reg[3] |-> ##2 o_out_left == $past(i_in_left, 2))
      else $error("bypass altered a sample");
   out_hold_a: assert property (o_out_valid && !i_out_ready |=> o_out_valid && $stable(o_out_right))
      else $error("output changed while stalled");
endmodule : cgm_gain_mute_checker

// [verif/tb.sv]
`timescale 1ns/1ps

module tb;
   localparam int unsigned MS = 10;
   logic        clk, rst, wr, rd, gm, hs, rs, iv, stall, ordy, got, ha, ra, ir, ov;
   logic [7:0]  addr, wd, rdat;
   logic [1:0]  lh, ls;
   logic [23:0] il, irt, ol, ort;
   logic [47:0] word;
   int          mismatches, n_checks, k, n;

   cgm_gain_mute #(.MS_CYCLES(MS)) cgm_gain_mute_i (.i_ref_clk(clk), .i_reset(rst),
      .i_reg_addr(addr), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wd), .o_reg_rdata(rdat),
      .i_global_mute(gm), .i_limit_hit(lh), .o_limit_status(ls), .i_hold_start(hs),
      .i_release_start(rs), .o_hold_active(ha), .o_release_active(ra), .i_in_valid(iv),
      .o_in_ready(ir), .i_in_left(il), .i_in_right(irt), .o_out_valid(ov),
      .i_out_ready(ordy), .o_out_left(ol), .o_out_right(ort));
   cgm_far_model cgm_far_model_i (.i_ref_clk(clk), .i_reset(rst), .i_stall(stall),
      .i_valid(ov), .i_word({ol, ort}), .o_ready(ordy), .o_got(got), .o_word(word));

   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(string nm, logic [48:0] e, logic [48:0] s);
      n_checks++;
      if (s !== e)
      begin
         mismatches++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask : chk

   task automatic wr_reg(logic [7:0] a, logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg

   task automatic rd_reg(logic [7:0] a, logic [7:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      chk("rdata", e, rdat);
   endtask : rd_reg

   // source holds the pair until taken, then shows inverted stale data
   task automatic push(logic [23:0] l, logic [23:0] r);
      @(posedge clk);
      iv <= 1'b1;
      il <= l;
      irt <= r;
      @(negedge clk);
      while (!ir) @(negedge clk);
      @(posedge clk);
      iv <= 1'b0;
      il <= ~l;
      irt <= ~r;
   endtask : push

   task automatic pass(logic [23:0] l, r, el, er);
      push(l, r);
      k = 0;
      @(negedge clk);
      while (!got && k < 50)
      begin
         @(negedge clk);
         k++;
      end
      chk("out pair", {1'b1, el, er}, {got, word});
   endtask : pass

   task automatic pulse(logic rel);
      @(posedge clk);
      if (rel) rs <= 1'b1; else hs <= 1'b1;
      @(posedge clk);
      rs <= 1'b0;
      hs <= 1'b0;
   endtask : pulse

   ////////////////////////////////////////////////////////////////////////////
   task automatic t_regs;
      logic [7:0] a [9] = '{8'h23, 8'h24, 8'h26, 8'h27, 8'h28, 8'h29, 8'h2a, 8'h22, 8'h25};
      logic [7:0] e [9] = '{8'h15, 8'h05, 8'h00, 8'h00, 8'h48, 8'h48, 8'h00, 8'h00, 8'h00};
      for (int i = 0; i < 9; i++) rd_reg(a[i], e[i]);
      wr_reg(8'h25, 8'h5a);
      rd_reg(8'h25, 8'h00);
      wr_reg(8'h29, 8'ha5);
      rd_reg(8'h29, 8'ha5);
      wr_reg(8'h29, 8'h48);
      $display("test regs done");
   endtask : t_regs

   task automatic t_gain;
      pass(24'h001000, 24'h002000, 24'h001000, 24'h002000);
      wr_reg(8'h27, 8'h0c);
      pass(24'h001000, 24'h002000, 24'h000800, 24'h001000);
      wr_reg(8'h27, 8'hff);
      pass(24'h001000, 24'h002000, 24'h000000, 24'h000000);
      wr_reg(8'h27, 8'h00);
      $display("test gain done");
   endtask : t_gain

   task automatic t_mute;
      wr_reg(8'h26, 8'h01);
      pass(24'h001000, 24'h002000, 24'h000000, 24'h002000);
      wr_reg(8'h26, 8'h02);
      pass(24'h001000, 24'h002000, 24'h001000, 24'h000000);
      wr_reg(8'h26, 8'h00);
      @(posedge clk) gm <= 1'b1;
      pass(24'h001000, 24'h002000, 24'h000000, 24'h000000);
      @(posedge clk) gm <= 1'b0;
      $display("test mute done");
   endtask : t_mute

   // level waits for a sign change unless the change-now bit is set
   task automatic t_zc;
      wr_reg(8'h28, 8'h54);
      pass(24'h001000, 24'h002000, 24'h001000, 24'h002000);
      pass(24'hfff000, 24'h002000, 24'hfff800, 24'h002000);
      wr_reg(8'h28, 8'h48);
      pass(24'h001000, 24'h002000, 24'h001000, 24'h002000);
      wr_reg(8'h24, 8'h07);
      wr_reg(8'h28, 8'h60);
      pass(24'h001000, 24'h002000, 24'h000400, 24'h002000);
      wr_reg(8'h28, 8'h48);
      wr_reg(8'h27, 8'h0c);
      wr_reg(8'h24, 8'h0f);
      pass(24'h123457, 24'h654321, 24'h123457, 24'h654321);
      wr_reg(8'h24, 8'h07);
      wr_reg(8'h27, 8'h00);
      $display("test crossing and bypass done");
   endtask : t_zc

   // shortest run length: 512 zeros pass, 513 engage the mute
   task automatic t_zrun;
      wr_reg(8'h23, 8'h00);
      for (int i = 0; i < 512; i++) pass(0, 0, 0, 0);
      pass(24'h001000, 24'h002000, 24'h001000, 24'h002000);
      for (int i = 0; i < 513; i++) pass(0, 0, 0, 0);
      pass(24'h001000, 24'h002000, 24'h000000, 24'h000000);
      wr_reg(8'h23, 8'h15);
      $display("test zero run done");
   endtask : t_zrun

   task automatic t_limit;
      @(posedge clk) lh <= 2'b11;
      @(posedge clk) lh <= 2'b00;
      @(negedge clk) chk("limit", 2'b11, ls);
      wr_reg(8'h24, 8'h87);
      @(negedge clk) chk("limit", 2'b00, ls);
      rd_reg(8'h24, 8'h87);
      wr_reg(8'h24, 8'h07);
      $display("test limit done");
   endtask : t_limit

   // tick phase runs free, so each window allows one tick of slack
   task automatic t_timer;
      pulse(0);
      @(negedge clk) chk("hold", 0, ha);
      wr_reg(8'h2a, 8'h03);
      pulse(0);
      repeat (2) @(negedge clk);
      chk("hold", 1, ha);
      repeat (43) @(negedge clk);
      chk("hold", 0, ha);
      wr_reg(8'h2a, 8'h82);
      pulse(0);
      repeat (90) @(negedge clk);
      chk("hold", 1, ha);
      repeat (120) @(negedge clk);
      chk("hold", 0, ha);
      wr_reg(8'h22, 8'h05);
      pulse(1);
      repeat (30) @(negedge clk);
      chk("release", 1, ra);
      repeat (40) @(negedge clk);
      chk("release", 0, ra);
      $display("test timers done");
   endtask : t_timer

   task automatic t_fifo;
      @(posedge clk) stall <= 1'b1;
      n = 0;
      @(negedge clk);
      while (ir && n < 40)
      begin
         push(n + 1, n + 1);
         n++;
         @(negedge clk);
      end
      chk("fill count", 33, n);
      @(posedge clk) stall <= 1'b0;
      for (int i = 1; i <= 33; i++)
      begin
         @(negedge clk);
         while (!got) @(negedge clk);
         chk("drain", {24'(i), 24'(i)}, word);
      end
      $display("test buffer done");
   endtask : t_fifo

   ////////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // whole sequence needs under 15k cycles
   initial
   begin
      repeat (60000) @(posedge clk);
      mismatches++;
      finish_test;
   end

   initial
   begin
      {rst, wr, rd, gm, hs, rs, iv, stall} = 8'h80;
      {addr, wd, lh, il, irt} = '0;
      mismatches = 0;
      n_checks = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      t_regs;
      t_gain;
      t_mute;
      t_zc;
      t_zrun;
      t_limit;
      t_timer;
      t_fifo;
      finish_test;
   end
endmodule : tb

bind cgm_gain_mute cgm_gain_mute_checker #(.MS_CYCLES(MS_CYCLES)) cgm_gain_mute_checker_i (.*);
